//--- pkg/rrsse_pkg.sv
// Shared constants and types for the return/rotate/sleep/subtract executor
package rrsse_pkg;

  // --------------------------------------------------------------------
  // Instruction word
  // --------------------------------------------------------------------
  localparam int          INSN_W          = 14;
  localparam logic [13:0] OP_RETURN       = 14'h0008;
  localparam logic [13:0] OP_SLEEP        = 14'h0063;
  localparam logic [5:0]  OP_ROT_LEFT     = 6'h0D;
  localparam logic [5:0]  OP_ROT_RIGHT    = 6'h0C;
  localparam logic [4:0]  OP_SUB_LIT      = 5'h1E;
  localparam int          OP6_HI          = 13;
  localparam int          OP6_LO          = 8;
  localparam int          OP5_LO          = 9;
  localparam int          DEST_BIT        = 7;
  localparam int          FADDR_W         = 7;

  // --------------------------------------------------------------------
  // Status bit positions and reset values
  // --------------------------------------------------------------------
  localparam int          ST_CARRY        = 0;
  localparam int          ST_HALF         = 1;
  localparam int          ST_ZERO         = 2;
  localparam int          ST_PD           = 3;
  localparam int          ST_TO           = 4;
  localparam logic [7:0]  W_RESET         = 8'h00;
  localparam logic [4:0]  STATUS_RESET    = 5'h18;
  localparam logic [12:0] PC_RESET        = 13'h0000;
  localparam logic [7:0]  WDT_CLEAR       = 8'h00;
  localparam logic [7:0]  PRESCALE_CLEAR  = 8'h00;

  typedef enum logic [1:0] {
    RRSSE_RUN,
    RRSSE_REFETCH,
    RRSSE_SLEEP
  } rrsse_state_type;

endpackage

//--- rtl/rrsse_exec.sv
// Executor for return, rotate via carry, sleep and subtract-from-literal
// ----------------------------------------------------------------------
// Summary of operation
// - Return pops stack top into PC
// - Return takes two cycles, second refetches
// - Rotate left: carry into bit0, bit7 out
// - Dest bit 0 writes W, 1 writes file
// - Rotate right: carry into bit7, bit0 out
// - Sleep clears power-down, sets timeout flag
// - Sleep clears watchdog counter and prescaler
// - Sleep halts oscillator until wake event
// - Subtract: literal minus W into W
// - Subtract leaves file registers untouched
// ----------------------------------------------------------------------
module rrsse_exec
  import rrsse_pkg::*;
#(
  parameter int PC_W = 13
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Instruction stream
  input  wire logic [INSN_W-1:0] insn,
  input  wire logic              insn_valid,
  input  wire logic              wake,
  // Call stack
  input  wire logic [PC_W-1:0]   stack_top,
  output logic                   stack_pop,
  // File register access
  output logic [FADDR_W-1:0]     file_addr,
  input  wire logic [7:0]        file_rdata,
  output logic [7:0]             file_wdata,
  output logic                   file_we,
  // Core state
  output logic [PC_W-1:0]        pc,
  output logic [7:0]             w_reg,
  output logic                   carry_flag,
  output logic                   half_carry_flag,
  output logic                   zero_flag,
  output logic                   power_down_flag_n,
  output logic                   timeout_flag_n,
  output logic [7:0]             watchdog_counter,
  output logic [7:0]             watchdog_prescaler,
  output logic                   osc_run,
  output logic                   fetch_en
);

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  rrsse_state_type state;
  rrsse_state_type next_state;
  logic            active;
  logic            is_ret;
  logic            is_sleep;
  logic            is_rl;
  logic            is_rr;
  logic            is_sub;
  logic            dest_file;
  logic [7:0]      lit;
  logic [7:0]      rot_res;
  logic            rot_carry;
  logic [8:0]      diff;
  logic [4:0]      diff_lo;

  assign active    = insn_valid && (state == RRSSE_RUN);
  assign is_ret    = active && (insn == OP_RETURN);
  assign is_sleep  = active && (insn == OP_SLEEP);
  assign is_rl     = active && (insn[OP6_HI:OP6_LO] == OP_ROT_LEFT);
  assign is_rr     = active && (insn[OP6_HI:OP6_LO] == OP_ROT_RIGHT);
  assign is_sub    = active && (insn[OP6_HI:OP5_LO] == OP_SUB_LIT);
  assign dest_file = insn[DEST_BIT];
  assign lit       = insn[7:0];

  // --------------------------------------------------------------------
  // Datapath
  // --------------------------------------------------------------------
  always_comb begin
    if (is_rl) begin
      rot_res   = {file_rdata[6:0], carry_flag};
      rot_carry = file_rdata[7];
    end else begin
      rot_res   = {carry_flag, file_rdata[7:1]};
      rot_carry = file_rdata[0];
    end
  end

  // Borrow-free means carry set: bit 8 of the 9-bit add of k + ~W + 1
  assign diff    = {1'b0, lit} + {1'b0, ~w_reg} + 9'h001;
  assign diff_lo = {1'b0, lit[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01;

  // Only rotates with dest=1 write the file; subtract never does
  assign file_addr  = insn[FADDR_W-1:0];
  assign file_we    = (is_rl || is_rr) && dest_file;
  assign file_wdata = rot_res;
  assign stack_pop  = is_ret;

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      RRSSE_RUN: begin
        if (is_ret) begin
          next_state = RRSSE_REFETCH;
        end else if (is_sleep) begin
          next_state = RRSSE_SLEEP;
        end
      end
      RRSSE_REFETCH: begin
        next_state = RRSSE_RUN;
      end
      RRSSE_SLEEP: begin
        if (wake) begin
          next_state = RRSSE_RUN;
        end
      end
      default: begin
        next_state = RRSSE_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= RRSSE_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Fetch is suppressed during the refetch slot and while asleep
  assign fetch_en = (state == RRSSE_RUN);
  assign osc_run  = (state != RRSSE_SLEEP);

  // --------------------------------------------------------------------
  // Program counter
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pc <= PC_RESET[PC_W-1:0];
    end else if (is_ret) begin
      pc <= stack_top;
    end else if (active && !is_sleep) begin
      pc <= pc + PC_W'(1);
    end
  end

  // --------------------------------------------------------------------
  // Working register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      w_reg <= W_RESET;
    end else if (is_sub) begin
      w_reg <= diff[7:0];
    end else if ((is_rl || is_rr) && !dest_file) begin
      w_reg <= rot_res;
    end
  end

  // --------------------------------------------------------------------
  // Arithmetic flags
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      carry_flag      <= STATUS_RESET[ST_CARRY];
      half_carry_flag <= STATUS_RESET[ST_HALF];
      zero_flag       <= STATUS_RESET[ST_ZERO];
    end else if (is_sub) begin
      carry_flag      <= diff[8];
      half_carry_flag <= diff_lo[4];
      zero_flag       <= (diff[7:0] == 8'h00);
    end else if (is_rl || is_rr) begin
      carry_flag      <= rot_carry;
    end
  end

  // --------------------------------------------------------------------
  // Sleep effects
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      power_down_flag_n <= STATUS_RESET[ST_PD];
      timeout_flag_n    <= STATUS_RESET[ST_TO];
    end else if (is_sleep) begin
      power_down_flag_n <= 1'b0;
      timeout_flag_n    <= 1'b1;
    end
  end

  // Watchdog keeps counting in sleep; the real tick source is elsewhere
  always_ff @(posedge ref_clk) begin
    if (srst || is_sleep) begin
      watchdog_counter   <= WDT_CLEAR;
      watchdog_prescaler <= PRESCALE_CLEAR;
    end else begin
      watchdog_prescaler <= watchdog_prescaler + 8'h01;
      if (watchdog_prescaler == 8'hFF) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  ret_pc_load_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_ret |=> pc == $past(stack_top) && state == RRSSE_REFETCH)
    else $error("return did not load stack top");

  ret_two_cyc_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_ret |=> !fetch_en ##1 fetch_en)
    else $error("return not two cycles");

  ret_flags_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_ret |=> $stable(carry_flag) && $stable(zero_flag))
    else $error("return changed flags");

  rot_left_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rl |=> carry_flag == $past(file_rdata[7]))
    else $error("rotate left carry wrong");

  rot_dest_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (is_rl || is_rr) && !dest_file |-> !file_we
      ##1 w_reg == $past(rot_res))
    else $error("rotate destination wrong");

  rot_right_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rr && dest_file |-> file_wdata[7] == carry_flag
      ##1 carry_flag == $past(file_rdata[0]))
    else $error("rotate right wrong");

  sleep_flags_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_sleep |=> !power_down_flag_n && timeout_flag_n
      && watchdog_counter == WDT_CLEAR)
    else $error("sleep flags wrong");

  sleep_halt_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_sleep ##1 !wake |=> !osc_run && $stable(pc))
    else $error("sleep did not halt");

  sub_result_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_sub |=> w_reg == 8'($past(lit) - $past(w_reg))
      && carry_flag == ($past(w_reg) <= $past(lit)))
    else $error("subtract result wrong");

  sub_half_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_sub |-> !file_we ##1
      half_carry_flag == ($past(w_reg[3:0]) <= $past(lit[3:0])))
    else $error("subtract half carry wrong");

  rot_only_c_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (is_rl || is_rr) |=> $stable(zero_flag) && $stable(half_carry_flag)
      && state == RRSSE_RUN)
    else $error("rotate touched other flags");

  ret_pop_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    stack_pop |-> insn_valid && fetch_en && insn == OP_RETURN)
    else $error("stack pop without return");

  ret_w_hold_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_ret |-> !file_we
      ##1 $stable(w_reg) && $stable(half_carry_flag))
    else $error("return changed working state");

  refetch_ign_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    state == RRSSE_REFETCH |=> $stable(w_reg) && $stable(pc)
      && $stable(carry_flag))
    else $error("refetch slot executed an instruction");

  halt_no_we_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !fetch_en |-> !file_we && !stack_pop)
    else $error("write or pop while fetch is off");

  rot_left_w_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rl && !dest_file |=> w_reg[0] == $past(carry_flag)
      && w_reg[7:1] == $past(file_rdata[6:0]))
    else $error("rotate left result wrong");

  rot_right_w_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rr && !dest_file |=> w_reg[7] == $past(carry_flag)
      && w_reg[6:0] == $past(file_rdata[7:1]))
    else $error("rotate right result wrong");

  rot_file_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (is_rl || is_rr) && dest_file |-> file_we
      ##1 $stable(w_reg))
    else $error("rotate to file wrong");

  rot_left_f_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rl && dest_file |-> file_wdata[0] == carry_flag
      && file_wdata[7:1] == file_rdata[6:0])
    else $error("rotate left file data wrong");

  sleep_presc_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_sleep |=> watchdog_prescaler == PRESCALE_CLEAR)
    else $error("sleep left prescaler running");

  sleep_enter_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_sleep |=> state == RRSSE_SLEEP && !fetch_en && $stable(pc))
    else $error("sleep not entered");

  sleep_wake_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    state == RRSSE_SLEEP && wake |=> fetch_en && osc_run)
    else $error("wake did not resume");

  sleep_hold_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    state == RRSSE_SLEEP |=> $stable(w_reg) && $stable(carry_flag)
      && $stable(zero_flag))
    else $error("instruction executed in sleep");

  sub_zero_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_sub |=> zero_flag == ($past(lit) == $past(w_reg)))
    else $error("subtract zero flag wrong");

  pd_hold_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !is_sleep |=> $stable(power_down_flag_n)
      && $stable(timeout_flag_n))
    else $error("power flags moved without sleep");

endmodule

//--- dv/rrsse_mem_model.sv
// Partner model: file registers and call stack seen by the executor
module rrsse_mem_model
  import rrsse_pkg::*;
#(
  parameter int PC_W = 13
) (
  // Clock
  input  wire logic               ref_clk,
  // File register side
  input  wire logic [FADDR_W-1:0] file_addr,
  input  wire logic [7:0]         file_wdata,
  input  wire logic               file_we,
  output logic [7:0]              file_rdata,
  // Call stack side
  input  wire logic               stack_pop,
  output logic [PC_W-1:0]         stack_top
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]      file_mem [2**FADDR_W];
  logic [PC_W-1:0] stack_mem [4];
  logic [1:0]      sp = 2'h1;

  // Combinational read, as the executor expects same-cycle data
  assign file_rdata = file_mem[file_addr];
  assign stack_top  = stack_mem[sp];

  always @(posedge ref_clk) begin
    if (file_we) begin
      file_mem[file_addr] <= file_wdata;
    end
    if (stack_pop) begin
      sp <= sp - 2'h1;
    end
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the return/rotate/sleep/subtract executor
module testbench import rrsse_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [13:0] insn = 14'h0000;
  logic        insn_valid = 1'b0;
  logic        wake = 1'b0;
  logic [12:0] stack_top, pc;
  logic [6:0]  file_addr;
  logic [7:0]  file_rdata, file_wdata, w_reg;
  logic [7:0]  watchdog_counter, watchdog_prescaler;
  logic        stack_pop, file_we, carry_flag, half_carry_flag, zero_flag;
  logic        power_down_flag_n, timeout_flag_n, osc_run, fetch_en;
  logic [7:0]  mw = 8'h00;
  logic        mc = 1'b0, mdc = 1'b0, mz = 1'b0, pop_seen, we_seen;
  int          n_fail = 0, checks = 0, i;

  always #10 ref_clk = ~ref_clk;

  rrsse_exec #(.PC_W(13)) rrsse_exec_i (.ref_clk, .srst, .insn, .insn_valid,
    .wake, .stack_top, .stack_pop, .file_addr, .file_rdata, .file_wdata,
    .file_we, .pc, .w_reg, .carry_flag, .half_carry_flag, .zero_flag,
    .power_down_flag_n, .timeout_flag_n, .watchdog_counter,
    .watchdog_prescaler, .osc_run, .fetch_en);

  rrsse_mem_model #(.PC_W(13)) rrsse_mem_model_i (.ref_clk, .file_addr,
    .file_wdata, .file_we, .file_rdata, .stack_pop, .stack_top);

  // ------------------------------------------
  // Compare, drive and report tasks
  // ------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkpc(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One instruction, then a gap cycle so strobes never double up
  task automatic issue(input logic [13:0] op);
    @(posedge ref_clk);
    insn       <= op;
    insn_valid <= 1'b1;
    #1;
    pop_seen = stack_pop;
    we_seen  = file_we;
    @(posedge ref_clk);
    insn_valid <= 1'b0;
    #1;
  endtask

  task automatic sub_lit(input logic [7:0] k);
    logic [7:0] e;
    e   = k - mw;
    mc  = (mw <= k);
    mdc = (mw[3:0] <= k[3:0]);
    mz  = (e == 8'h00);
    mw  = e;
    issue({OP_SUB_LIT, 1'b0, k});
    chk8(w_reg, mw);
    chk1(we_seen, 1'b0);
    chk1(carry_flag, mc);
    chk1(half_carry_flag, mdc);
    chk1(zero_flag, mz);
  endtask

  task automatic rot(input logic left, input logic d, input logic [7:0] v);
    logic [7:0] e;
    e = left ? {v[6:0], mc} : {mc, v[7:1]};
    rrsse_mem_model_i.file_mem[5] = v;
    issue({left ? OP_ROT_LEFT : OP_ROT_RIGHT, d, 7'h05});
    mc = left ? v[7] : v[0];
    if (!d) mw = e;
    chk8(w_reg, mw);
    chk8(rrsse_mem_model_i.file_mem[5], d ? e : v);
    chk1(carry_flag, mc);
    chk1(half_carry_flag, mdc);
    chk1(zero_flag, mz);
    chk1(fetch_en, 1'b1);
  endtask

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    rrsse_mem_model_i.stack_mem[0] = 13'h0456;
    rrsse_mem_model_i.stack_mem[1] = 13'h0123;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk1(power_down_flag_n, 1'b1);
    sub_lit(8'h00);
    sub_lit(8'h35);
    sub_lit(8'h12);
    sub_lit(8'hF0);
    sub_lit(8'h0F);
    sub_lit(8'h80);
    rot(1'b1, 1'b0, 8'hE6);
    rot(1'b1, 1'b1, 8'h01);
    rot(1'b0, 1'b0, 8'h81);
    rot(1'b0, 1'b1, 8'h02);
    issue(OP_RETURN);
    chk1(pop_seen, 1'b1);
    chkpc(pc, 13'h0123);
    chk1(carry_flag, mc);
    chk1(fetch_en, 1'b0);
    @(posedge ref_clk);
    #1;
    chk1(fetch_en, 1'b1);
    issue(OP_RETURN);
    chkpc(pc, 13'h0456);
    // Long enough for the prescaler to wrap, so both clears are visible
    repeat (300) @(posedge ref_clk);
    issue(OP_SLEEP);
    chk1(power_down_flag_n, 1'b0);
    chk1(timeout_flag_n, 1'b1);
    chk8(watchdog_counter, WDT_CLEAR);
    chk8(watchdog_prescaler, PRESCALE_CLEAR);
    chk1(osc_run, 1'b0);
    issue({OP_SUB_LIT, 9'h055});
    chk8(w_reg, mw);
    chkpc(pc, 13'h0456);
    chk1(fetch_en, 1'b0);
    @(posedge ref_clk);
    wake <= 1'b1;
    for (i = 0; i < 8 && fetch_en !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (fetch_en !== 1'b1) begin
      n_fail++;
    end else begin
      chk1(osc_run, 1'b1);
      @(posedge ref_clk);
      wake <= 1'b0;
      sub_lit(8'h10);
    end
    final_report();
  end
endmodule
